// ### logic/cma_pkg.sv
package cma_pkg;

  // ****************************************************************
  // Register map and field positions.
  // ****************************************************************
  localparam logic [7:0] ADDR_MODE_OFS = 8'h10;
  localparam logic [7:0] DATA_WORD_OFS = 8'h20;
  localparam logic [7:0] CONFIG_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [7:0] WORD_ALIGN = 8'hFC;
  localparam logic [15:0] MODE_RESET = 16'h0800;
  localparam logic [15:0] MODE_MASK = 16'h3FFF;
  localparam logic [15:0] WORD_MASK = 16'h3FFF;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam int OM0_BIT = 5;
  localparam int PAIR_LSB = 6;
  localparam int READ_BIT = 8;
  localparam int CM_BIT = 9;
  localparam int BID_BIT = 10;
  localparam int CAC_BIT = 11;
  localparam int LIMITED_CYCLICAL_BIT_BIT = 12;
  localparam int TC_BIT = 13;
  localparam int LOOP_BIT = 8;
  localparam int SCR_BIT = 9;
  localparam int SYNC_BIT = 10;
  localparam int SEQUENCE_ANALYZER_ENABLE_BIT = 11;
  localparam int INS_BIT = 12;
  localparam int SEQUENCE_GENERATOR_ENABLE_BIT = 13;
  localparam int CFG_RATE_BIT = 0;
  localparam int GCI_B2_BIT = 1;

  // ****************************************************************
  // Memory sizes, limits and scrambler taps.
  // ****************************************************************
  localparam int CM_DEPTH = 256;
  localparam int SCR_SLOTS = 32;
  localparam logic [7:0] LAST_ADDR = 8'hFF;
  localparam logic [4:0] SLOT_LAST = 5'h1F;
  localparam logic [5:0] SCR_MAX = 6'h20;
  localparam logic [2:0] GCI_MUX_A = 3'h4;
  localparam logic [2:0] GCI_MUX_B = 3'h5;
  localparam int SCR_LEN = 23;
  localparam int TAP_A = 17;
  localparam int TAP_B = 22;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_CLEAR, ST_IDLE, ST_FILL, ST_BID2} cma_state_e;

endpackage

// ### logic/cma_connection_ctrl.sv
`timescale 1ns/1ps
module cma_connection_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic slot_strobe,
  input wire logic [7:0] slot_addr,
  input wire logic [7:0] slot_data,
  input wire logic bit_tick,
  input wire logic dm_wr_en,
  input wire logic [7:0] dm_wr_addr,
  input wire logic [7:0] dm_wr_data,
  output logic [7:0] slot_out_data,
  output logic sequence_analyzer_enable,
  output logic analyzer_from_generator,
  output logic programmable_sync_pin,
  output logic scramble_active,
  output logic descramble_active,
  output logic [2:0] route_in_mux,
  output logic [5:0] route_in_slot,
  output logic [3:0] sample_three_quarter
);

  // ****************************************************************
  // Storage and state.
  // ****************************************************************
  logic [15:0] cm_mem [cma_pkg::CM_DEPTH];
  logic [7:0] dm_mem [cma_pkg::CM_DEPTH];
  logic [cma_pkg::SCR_LEN-1:0] scr_state_ff [cma_pkg::SCR_SLOTS];
  logic aw_free_ff, w_free_ff, bvalid_ff, ar_free_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [15:0] mode_ff, word_ff;
  logic [4:0] cfg_ff;
  logic [5:0] scr_cnt_ff;
  logic [7:0] clr_ptr_ff;
  cma_pkg::cma_state_e state_ff, nxt_state;
  logic [7:0] out_data_ff;
  logic analyzer_ff, from_gen_ff, sync_ff, scr_act_ff, dscr_act_ff;
  logic [2:0] route_mux_ff;
  logic [5:0] route_slot_ff;
  logic [3:0] sample_ff;
  logic cm_we;
  logic [7:0] cm_wa;
  logic [15:0] cm_wd, cm_wd_g;

  // V.29 self-synchronising scrambler over one byte, LSB first.
  function automatic logic [30:0] cma_v29(input logic [7:0] din,
                                          input logic [22:0] seed,
                                          input logic descr);
    logic [22:0] s;
    logic [7:0] dout;
    logic fb;
    s = seed;
    dout = 8'h00;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = s[cma_pkg::TAP_A] ^ s[cma_pkg::TAP_B];
      dout[i] = din[i] ^ fb;
      s = {s[cma_pkg::SCR_LEN-2:0], descr ? din[i] : dout[i]};
    end
    return {s, dout};
  endfunction

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  wire aw_hs = awvalid && aw_free_ff;
  wire w_hs = wvalid && w_free_ff;
  wire ar_hs = arvalid && ar_free_ff;
  wire idle_w = (state_ff == cma_pkg::ST_IDLE);
  wire wr_fire = !aw_free_ff && !w_free_ff && !bvalid_ff && idle_w;
  wire [7:0] wr_ofs = aw_addr_ff & cma_pkg::WORD_ALIGN;
  wire [7:0] ar_ofs = araddr & cma_pkg::WORD_ALIGN;
  wire wr_mode = wr_fire && (wr_ofs == cma_pkg::ADDR_MODE_OFS);
  wire wr_word = wr_fire && (wr_ofs == cma_pkg::DATA_WORD_OFS);
  wire wr_cfg = wr_fire && (wr_ofs == cma_pkg::CONFIG_OFS);
  wire wr_hit = (wr_ofs == cma_pkg::ADDR_MODE_OFS) || (wr_ofs == cma_pkg::DATA_WORD_OFS) ||
                (wr_ofs == cma_pkg::CONFIG_OFS) || (wr_ofs == cma_pkg::STATUS_OFS);
  wire [15:0] mode_wr_val = {w_strb_ff[1] ? w_data_ff[15:8] : mode_ff[15:8],
                             w_strb_ff[0] ? w_data_ff[7:0] : mode_ff[7:0]} & cma_pkg::MODE_MASK;
  wire [15:0] word_wr_val = {w_strb_ff[1] ? w_data_ff[15:8] : word_ff[15:8],
                             w_strb_ff[0] ? w_data_ff[7:0] : word_ff[7:0]} & cma_pkg::WORD_MASK;

  // Access launch from a destination byte write, split by mode bits.
  wire launch = wr_mode && w_strb_ff[0];
  wire [7:0] new_dest = mode_wr_val[7:0];
  wire new_cyc = mode_wr_val[cma_pkg::CAC_BIT] | mode_wr_val[cma_pkg::LIMITED_CYCLICAL_BIT_BIT];
  wire launch_dm = launch && !mode_wr_val[cma_pkg::CM_BIT];
  wire launch_rd = launch && mode_wr_val[cma_pkg::CM_BIT] && mode_wr_val[cma_pkg::READ_BIT];
  wire launch_wr = launch && mode_wr_val[cma_pkg::CM_BIT] && !mode_wr_val[cma_pkg::READ_BIT];
  wire launch_fill = launch_wr && new_cyc;
  wire launch_one = launch_wr && !new_cyc;
  wire launch_bid = launch_one && mode_wr_val[cma_pkg::BID_BIT] &&
                    !mode_wr_val[cma_pkg::TC_BIT];

  // Current destination, end of a cyclical run and read-side stepping.
  wire [7:0] dest_w = mode_ff[7:0];
  wire [7:0] nxt_dest = 8'(dest_w + 8'h01);
  wire [7:0] last_w = mode_ff[cma_pkg::CAC_BIT] ? cma_pkg::LAST_ADDR :
                      {mode_ff[7:cma_pkg::OM0_BIT], cma_pkg::SLOT_LAST};
  wire at_last = (dest_w == last_w);
  wire rd_cyc = mode_ff[cma_pkg::CM_BIT] && mode_ff[cma_pkg::READ_BIT] &&
                (mode_ff[cma_pkg::CAC_BIT] | mode_ff[cma_pkg::LIMITED_CYCLICAL_BIT_BIT]);
  wire advance = ar_hs && (ar_ofs == cma_pkg::DATA_WORD_OFS) && rd_cyc && !at_last &&
                 idle_w && !wr_fire;
  wire fill_step = (state_ff == cma_pkg::ST_FILL) && !at_last;
  wire [3:0] cfg_fast = cfg_ff[4:1];

  // Decoded destination: slot and multiplex for slow or fast pairs.
  wire dest_fast = cfg_fast[dest_w[7:cma_pkg::PAIR_LSB]];
  wire [5:0] dest_slot = dest_fast ? {dest_w[4:0], dest_w[cma_pkg::OM0_BIT]} :
                         {1'b0, dest_w[4:0]};
  wire [2:0] dest_mux = dest_fast ? {dest_w[7:cma_pkg::PAIR_LSB], 1'b0} :
                        dest_w[7:cma_pkg::OM0_BIT];

  // Read data selection.
  wire rd_hit = (ar_ofs == cma_pkg::ADDR_MODE_OFS) || (ar_ofs == cma_pkg::DATA_WORD_OFS) ||
                (ar_ofs == cma_pkg::CONFIG_OFS) || (ar_ofs == cma_pkg::STATUS_OFS);
  wire [31:0] rd_val =
    (ar_ofs == cma_pkg::ADDR_MODE_OFS) ? {16'h0000, mode_ff} :
    (ar_ofs == cma_pkg::DATA_WORD_OFS) ? {16'h0000, word_ff} :
    (ar_ofs == cma_pkg::CONFIG_OFS) ? {27'h0000000, cfg_ff} :
    (ar_ofs == cma_pkg::STATUS_OFS) ? {13'h0000, dest_mux, 2'h0, dest_slot, 1'b0,
                                       scr_cnt_ff, !idle_w} : 32'h00000000;

  // ****************************************************************
  // Connection memory write port and scramble admission.
  // ****************************************************************
  always_comb begin
    cm_we = 1'b0;
    cm_wa = dest_w;
    cm_wd = 16'h0000;
    case (state_ff)
      cma_pkg::ST_CLEAR: begin
        cm_we = 1'b1;
        cm_wa = clr_ptr_ff;
      end
      cma_pkg::ST_FILL: begin
        cm_we = 1'b1;
        cm_wd = mode_ff[cma_pkg::TC_BIT] ? {word_ff[15:8], dest_w} : word_ff;
      end
      cma_pkg::ST_BID2: begin
        cm_we = 1'b1;
        cm_wa = word_ff[7:0];
        cm_wd = {word_ff[15:8], dest_w};
        cm_wd[cma_pkg::LOOP_BIT] = 1'b0;
      end
      cma_pkg::ST_IDLE: begin
        cm_we = launch_one;
        cm_wa = new_dest;
        cm_wd = mode_wr_val[cma_pkg::TC_BIT] ? {word_ff[15:8], new_dest} : word_ff;
      end
      default: begin
        cm_we = 1'b0;
      end
    endcase
  end

  // A scramble bit is kept only on a free B1/B2 or plain slot within the cap.
  wire old_scr = cm_mem[cm_wa][cma_pkg::SCR_BIT];
  wire wa_gci = (cm_wa[7:cma_pkg::OM0_BIT] == cma_pkg::GCI_MUX_A) ||
                (cm_wa[7:cma_pkg::OM0_BIT] == cma_pkg::GCI_MUX_B);
  wire scr_ok = cm_wd[cma_pkg::SCR_BIT] && !(wa_gci && cm_wa[cma_pkg::GCI_B2_BIT]) &&
                (old_scr || (scr_cnt_ff < cma_pkg::SCR_MAX));
  wire counting = cm_we && (state_ff != cma_pkg::ST_CLEAR);

  always_comb begin
    cm_wd_g = cm_wd;
    cm_wd_g[cma_pkg::SCR_BIT] = scr_ok;
  end

  // Memory writes; contents carry no reset, the clear walk zeroes the connection memory only.
  always_ff @(posedge aclk) begin
    if (cm_we) begin
      cm_mem[cm_wa] <= cm_wd_g;
    end
    if (dm_wr_en) begin
      dm_mem[dm_wr_addr] <= dm_wr_data;
    end
  end

  // Count of scrambled entries follows every counted write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scr_cnt_ff <= 6'h00;
    end else if (counting) begin
      scr_cnt_ff <= 6'(scr_cnt_ff + {5'h00, scr_ok} - {5'h00, old_scr});
    end
  end

  // ****************************************************************
  // Access sequencer.
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cma_pkg::ST_CLEAR: begin
        if (clr_ptr_ff == cma_pkg::LAST_ADDR) begin
          nxt_state = cma_pkg::ST_IDLE;
        end
      end
      cma_pkg::ST_IDLE: begin
        if (launch_fill) begin
          nxt_state = cma_pkg::ST_FILL;
        end else if (launch_bid) begin
          nxt_state = cma_pkg::ST_BID2;
        end
      end
      cma_pkg::ST_FILL: begin
        if (at_last) begin
          nxt_state = cma_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = cma_pkg::ST_IDLE;
      end
    endcase
  end

  // State, clear pointer and configuration.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= cma_pkg::ST_CLEAR;
      clr_ptr_ff <= 8'h00;
      cfg_ff <= cma_pkg::CFG_RESET;
    end else begin
      state_ff <= nxt_state;
      clr_ptr_ff <= 8'(clr_ptr_ff + 8'h01);
      if (wr_cfg && w_strb_ff[0]) begin
        cfg_ff <= w_data_ff[4:0];
      end
    end
  end

  // Mode register; cyclical runs step the destination byte.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= cma_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_ff <= mode_wr_val;
    end else if (fill_step || advance) begin
      mode_ff[7:0] <= nxt_dest;
    end
  end

  // Data word: software value, or memory contents fetched by an access.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_ff <= 16'h0000;
    end else if (wr_word) begin
      word_ff <= word_wr_val;
    end else if (launch_dm) begin
      word_ff <= {8'h00, dm_mem[new_dest]};
    end else if (launch_rd) begin
      word_ff <= cm_mem[new_dest] & cma_pkg::WORD_MASK;
    end else if (advance) begin
      word_ff <= cm_mem[nxt_dest] & cma_pkg::WORD_MASK;
    end
  end

  // ****************************************************************
  // AXI4-Lite channels.
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_free_ff <= 1'b1;
      w_free_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= cma_pkg::RESP_OKAY;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_free_ff <= 1'b0;
        aw_addr_ff <= awaddr;
      end
      if (w_hs) begin
        w_free_ff <= 1'b0;
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
      if (wr_fire) begin
        aw_free_ff <= 1'b1;
        w_free_ff <= 1'b1;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? cma_pkg::RESP_OKAY : cma_pkg::RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_free_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= cma_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      ar_free_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_hit ? cma_pkg::RESP_OKAY : cma_pkg::RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
      ar_free_ff <= 1'b1;
    end
  end

  // ****************************************************************
  // Matrix side: per-slot controls from the connection word.
  // ****************************************************************
  wire [15:0] slot_ent = cm_mem[slot_addr];
  wire [4:0] slot_idx = slot_addr[4:0];
  wire slot_gci = (slot_addr[7:cma_pkg::OM0_BIT] == cma_pkg::GCI_MUX_A) ||
                  (slot_addr[7:cma_pkg::OM0_BIT] == cma_pkg::GCI_MUX_B);
  wire slot_scr = slot_ent[cma_pkg::SCR_BIT];
  wire slot_sync = slot_ent[cma_pkg::SYNC_BIT];
  wire slot_sequence_analyzer_enable = slot_ent[cma_pkg::SEQUENCE_ANALYZER_ENABLE_BIT];
  wire slot_ins = slot_ent[cma_pkg::INS_BIT];
  wire slot_gen = slot_ins && slot_ent[cma_pkg::SEQUENCE_GENERATOR_ENABLE_BIT];
  wire [30:0] v29_res = cma_v29(slot_data, scr_state_ff[slot_idx], slot_gci);
  wire [7:0] src_w = slot_ent[7:0];
  wire src_fast = cfg_fast[src_w[7:cma_pkg::PAIR_LSB]];

  // Per-slot outputs are loaded at each slot strobe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data_ff <= 8'h00;
      analyzer_ff <= 1'b0;
      from_gen_ff <= 1'b0;
      sync_ff <= 1'b0;
      scr_act_ff <= 1'b0;
      dscr_act_ff <= 1'b0;
      route_mux_ff <= 3'h0;
      route_slot_ff <= 6'h00;
      for (int k = 0; k < cma_pkg::SCR_SLOTS; k++) begin
        scr_state_ff[k] <= '0;
      end
    end else if (slot_strobe) begin
      out_data_ff <= slot_scr ? v29_res[7:0] : slot_data;
      if (slot_scr) begin
        scr_state_ff[slot_idx] <= v29_res[30:8];
      end
      analyzer_ff <= slot_sequence_analyzer_enable && (!slot_ins || slot_gen);
      from_gen_ff <= slot_sequence_analyzer_enable && slot_gen;
      sync_ff <= slot_sync;
      scr_act_ff <= slot_scr && !slot_gci;
      dscr_act_ff <= slot_scr && slot_gci;
      route_mux_ff <= src_fast ? {src_w[7:cma_pkg::PAIR_LSB], 1'b0} :
                      src_w[7:cma_pkg::OM0_BIT];
      route_slot_ff <= src_fast ? {src_w[4:0], src_w[cma_pkg::OM0_BIT]} :
                       {1'b0, src_w[4:0]};
    end else if (bit_tick) begin
      sync_ff <= 1'b0;
    end
  end

  // Sampling phase per pin pair: three-quarter unless fast at low rate.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_ff <= 4'hF;
    end else begin
      sample_ff <= {4{cfg_ff[cma_pkg::CFG_RATE_BIT]}} | ~cfg_fast[3:0];
    end
  end

  // Output ports from their registers.
  assign awready = aw_free_ff;
  assign wready = w_free_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = ar_free_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign slot_out_data = out_data_ff;
  assign sequence_analyzer_enable = analyzer_ff;
  assign analyzer_from_generator = from_gen_ff;
  assign programmable_sync_pin = sync_ff;
  assign scramble_active = scr_act_ff;
  assign descramble_active = dscr_act_ff;
  assign route_in_mux = route_mux_ff;
  assign route_in_slot = route_slot_ff;
  assign sample_three_quarter = sample_ff;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence fill_entered;
    launch_fill ##1 (state_ff == cma_pkg::ST_FILL);
  endsequence

  chk_sync_follows_bit: assert property (slot_strobe |=> sync_ff == $past(slot_sync))
    else $error("sync pin does not follow connection bit");
  chk_sync_one_bit: assert property (bit_tick && !slot_strobe |=> !sync_ff)
    else $error("sync pin stays high past one bit");
  chk_analyzer_off: assert property (slot_strobe && !slot_sequence_analyzer_enable |=> !analyzer_ff)
    else $error("analyzer enabled without its bit");
  chk_plain_pass: assert property (slot_strobe && !slot_scr
                                   |=> out_data_ff == $past(slot_data))
    else $error("unscrambled slot was modified");
  chk_scramble_cap: assert property (scr_cnt_ff <= cma_pkg::SCR_MAX)
    else $error("scramble count above cap");
  chk_gci_b_only: assert property (cm_we && wa_gci && cm_wa[cma_pkg::GCI_B2_BIT]
                                   |-> !cm_wd_g[cma_pkg::SCR_BIT])
    else $error("scramble kept on non-B GCI slot");
  chk_fill_steps: assert property (fill_entered ##0 !at_last
                                   |=> dest_w == $past(nxt_dest))
    else $error("cyclical fill did not step address");
  chk_fill_stops: assert property ((state_ff == cma_pkg::ST_FILL) && at_last
                                   |=> state_ff == cma_pkg::ST_IDLE)
    else $error("cyclical fill ran past last location");
  chk_bid_two_writes: assert property (launch_bid |-> cm_we ##1
                                       (state_ff == cma_pkg::ST_BID2) && cm_we
                                       ##1 idle_w)
    else $error("bidirectional write not two writes");
  chk_dm_read_byte: assert property (launch_dm |=> word_ff[15:8] == 8'h00 && !cm_we)
    else $error("data memory read produced bad word");
  chk_rate_phase: assert property (cfg_ff[cma_pkg::CFG_RATE_BIT] |=> &sample_ff)
    else $error("high rate not sampled at three quarter");

endmodule

// ### sim/cma_cpu_model.sv
`timescale 1ns/1ps
// ****
// Processor on the register bus.
// ****
module cma_cpu_model (
  input logic aclk,
  input logic awready,
  input logic wready,
  input logic bvalid,
  input logic [1:0] bresp,
  input logic arready,
  input logic rvalid,
  input logic [1:0] rresp,
  input logic [31:0] rdata,
  output logic [7:0] awaddr,
  output logic awvalid,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  output logic rready
);
  // The bus is idle at time zero.
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  // Each channel drops valid at the edge where it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 2000; n++) begin
      @(posedge aclk);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      if (bvalid) break;
    end
    if (n == 2000) tb.fail_wait();
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (n = 0; n < 2000; n++) begin
      @(posedge aclk);
      arvalid <= arvalid & ~arready;
      if (rvalid) break;
    end
    if (n == 2000) tb.fail_wait();
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
// ****
// Bench with a connection entry model.
// ****
module tb;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid;
  logic rready, slot_strobe, bit_tick, dm_wr_en, sequence_analyzer_enable, scramble_active;
  logic analyzer_from_generator, programmable_sync_pin, descramble_active, g;
  logic [7:0] awaddr, araddr, slot_addr, slot_data, dm_wr_addr, dm_wr_data, slot_out_data, d, b;
  logic [31:0] wdata, rdata, w, rv;
  logic [3:0] wstrb, sample_three_quarter;
  logic [1:0] bresp, rresp, rr;
  logic [2:0] route_in_mux;
  logic [5:0] route_in_slot;
  logic [15:0] cm[256];
  logic [22:0] sst[32] = '{default: 23'h0};
  logic [4:0] cf;
  logic f;
  logic [31:0] e;
  logic [7:0] md[3] = '{8'h02, 8'h06, 8'h22};
  int errors = 0;
  int checked = 0;
  // Per-slot outputs gathered for one comparison.
  wire [13:0] outs = {sequence_analyzer_enable, analyzer_from_generator, programmable_sync_pin,
    scramble_active, descramble_active, route_in_mux, route_in_slot};
  cma_connection_ctrl dut_u (.*);
  cma_cpu_model cpu_u (.*);
  // Clock of 10 ns period.
  initial forever #5 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic fail_wait();
    errors++;
    end_of_test();
  endtask
  task automatic look(input logic [7:0] a);
    cpu_u.wr(8'h10, {24'h000003, a}, rr);
    cpu_u.rd(8'h20, rv, rr);
    chk(rv, {16'h0, cm[a]});
  endtask
  // Number of modelled entries that carry the scramble bit.
  function automatic int cnt();
    int n;
    n = 0;
    foreach (cm[k]) n += cm[k][9];
    return n;
  endfunction
  // Modelled entry write: no scramble on GCI slots other than B1/B2, and 32 entries at most.
  task automatic put(input logic [7:0] a, input logic [15:0] v);
    logic [15:0] u;
    u = v;
    if ((a[7:5] == 3'h4 || a[7:5] == 3'h5) && a[1] || (!cm[a][9] && cnt() >= 32)) u[9] = 1'b0;
    cm[a] = u;
  endtask
  // Bench scrambler: one register per slot number, feedback after 18 and 23 bits.
  function automatic logic [7:0] v29(input logic [7:0] x, input logic [4:0] s, input logic de);
    logic [7:0] y;
    y = 8'h00;
    for (int j = 0; j < 8; j++) begin
      y[j] = x[j] ^ sst[s][17] ^ sst[s][22];
      sst[s] = {sst[s][21:0], de ? x[j] : y[j]};
    end
    return y;
  endfunction
  // Main sequence.
  initial begin
    {aresetn, slot_strobe, bit_tick, dm_wr_en, slot_addr, slot_data, dm_wr_addr, dm_wr_data} = '0;
    foreach (cm[k]) cm[k] = 16'h0;
    void'($urandom(32'h98991A46));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cpu_u.rd(8'h10, rv, rr);
    chk(rv, 32'h800);
    cpu_u.rd(8'h30, rv, rr);
    chk({rv[29:0], rr}, 32'h2);
    cpu_u.wr(8'h30, 32'h0, rr);
    chk({30'h0, rr}, 32'h2);
    // Plain, bidirectional and transparent writes.
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      w = $urandom & 32'h3DFF;
      if (w[7:0] == d) w[7:0] = ~d;
      cpu_u.wr(8'h20, w, rr);
      cpu_u.wr(8'h10, {16'h0, md[i % 3], d}, rr);
      cm[d] = (i % 3 == 2) ? {w[15:8], d} : w[15:0];
      if (i % 3 == 1) cm[w[7:0]] = {w[15:9], 1'b0, d};
      look(d);
      look(w[7:0]);
    end
    // Data memory reads; the read bit has no effect there.
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      d = 8'($urandom);
      @(posedge aclk);
      {dm_wr_en, dm_wr_addr, dm_wr_data} <= {1'b1, b, d};
      @(posedge aclk);
      dm_wr_en <= 1'b0;
      cpu_u.wr(8'h10, {23'h0, 1'($urandom), b}, rr);
      cpu_u.rd(8'h20, rv, rr);
      chk(rv, {24'h0, d});
    end
    // Limited fill, then auto-incrementing reads.
    b = {3'($urandom), 5'h1C};
    w = $urandom & 32'h3DFF;
    cpu_u.wr(8'h20, w, rr);
    cpu_u.wr(8'h10, {24'h000012, b}, rr);
    for (int k = 0; k < 4; k++) cm[b + k] = w[15:0];
    cpu_u.wr(8'h10, {24'h000013, b}, rr);
    for (int k = 0; k < 4; k++) begin
      cpu_u.rd(8'h20, rv, rr);
      chk(rv, {16'h0, cm[b + k]});
    end
    look(b + 8'h04);
    // Full transparent fill with scrambling; only 32 entries keep the bit.
    w = $urandom & 32'h3FFF | 32'h200;
    cpu_u.wr(8'h20, w, rr);
    cpu_u.wr(8'h10, {24'h00002A, 8'hC0}, rr);
    for (int k = 192; k < 256; k++) put(8'(k), {w[15:8], 8'(k)});
    look(8'hDF);
    look(8'hFF);
    // A second fill without scrambling frees the budget again.
    w[9] = 1'b0;
    cpu_u.wr(8'h20, w, rr);
    cpu_u.wr(8'h10, {24'h00002A, 8'hC0}, rr);
    for (int k = 192; k < 256; k++) put(8'(k), {w[15:8], 8'(k)});
    look(8'hC0);
    // Slot outputs; each slot number is used once.
    for (int i = 0; i < 6; i++) begin
      d = {3'($urandom), 5'(i)};
      w = $urandom & 32'h3FFF;
      g = d[7:5] == 3'h4 || d[7:5] == 3'h5;
      cf = 5'($urandom);
      cpu_u.wr(8'h24, {27'h0, cf}, rr);
      #1;
      chk({28'h0, sample_three_quarter}, {28'h0, {4{cf[0]}} | ~cf[4:1]});
      chk({30'h0, rr}, 32'h0);
      cpu_u.wr(8'h20, w, rr);
      cpu_u.wr(8'h10, {24'h000002, d}, rr);
      put(d, w[15:0]);
      w[9] = cm[d][9];
      look(d);
      f = cf[1 + d[7:6]];
      e = {13'h0, f ? {d[7:6], 1'b0} : d[7:5], 2'h0, f ? {d[4:0], d[5]} : {1'b0, d[4:0]},
        1'b0, 6'(cnt()), 1'b0};
      cpu_u.rd(8'h28, rv, rr);
      chk(rv, e);
      @(posedge aclk);
      {slot_strobe, slot_addr, slot_data} <= {1'b1, d, 8'($urandom)};
      @(posedge aclk);
      {slot_strobe, bit_tick} <= 2'h1;
      #1;
      f = cf[1 + w[7:6]];
      rv = {18'h0, w[11] & (!w[12] | w[13]), &w[13:11], w[10], w[9] & !g, w[9] & g,
        f ? {w[7:6], 1'b0} : w[7:5], f ? {w[4:0], w[5]} : {1'b0, w[4:0]}};
      chk({18'h0, outs}, rv);
      chk({24'h0, slot_out_data}, {24'h0, w[9] ? v29(slot_data, d[4:0], g) : slot_data});
      @(posedge aclk);
      bit_tick <= 1'b0;
      @(posedge aclk);
      #1;
      chk({31'h0, programmable_sync_pin}, 32'h0);
    end
    end_of_test();
  end
endmodule
